// [logic/tgp_port.sv]
// third gpio port: apb registers, pin muxing and peripheral overrides
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "tgp_params.svh"
module tgp_port (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire tgp_pkg::tgp_word_type i_pwdata,
	output tgp_pkg::tgp_word_type o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire tgp_pkg::tgp_byte_type i_pin_in,
	output tgp_pkg::tgp_byte_type o_pin_out,
	output tgp_pkg::tgp_byte_type o_pin_oe,
	input wire logic i_capture_two_pin_select,
	input wire logic i_cmp2_out,
	input wire logic i_ecmp_out,
	input wire logic i_pwma_out,
	input wire logic i_pwm_shutdown,
	output logic o_cmp2_capture_in,
	output logic o_cmp2_alt_route,
	output logic o_ecmp_capture_in,
	output logic o_timer_counter_clock_in,
	output logic o_timer_osc_active
);
	import tgp_pkg::*;

	// software-visible state
	tgp_byte_type latch_q;
	tgp_byte_type dir_q;
	logic [`TGP_CTL_WIDTH-1:0] ctl_q;

	// three sampler stages and the filtered pin levels
	tgp_byte_type s1_q;
	tgp_byte_type s2_q;
	tgp_byte_type s3_q;
	tgp_byte_type pin_q;
	tgp_byte_type pin_d;

	// next values of the pin driver flops
	tgp_byte_type out_d;
	tgp_byte_type oe_d;

	// bus decode
	logic setup_phase;
	logic access_phase;
	logic wr_en;
	logic rd_en;
	logic sel_pin;
	logic sel_latch;
	logic sel_dir;
	logic sel_ctl;
	logic hit;
	logic wr_latch;
	logic wr_dir;
	logic wr_ctl;
	tgp_byte_type rdsel;
	tgp_word_type prdata_d;
	logic pready_d;
	logic pslverr_d;

	// peripheral enables from the control register
	logic osc_en;
	logic cmp2_en;
	logic ecmp_en;
	logic pwma_en;
	logic shdn_float;

	// who owns each shared pin this cycle
	logic unit2_here;
	logic cmp2_drives;
	logic ecmp_drives;
	logic pwma_drives;
	logic pwma_floats;
	logic cmp2_listens;
	logic ecmp_listens;
	logic tcki_listens;

	// next values of the peripheral-side outputs
	logic cmp2_cap_d;
	logic alt_route_d;
	logic ecmp_cap_d;
	logic tcki_d;
	logic osc_active_d;

	// true when the bus address names the given register word
	function automatic logic tgp_addr_is(input logic [11:0] a,
		input logic [11:0] off);
		return a == off;
	endfunction

	// filtered level: follow the sampler only where its last two stages
	// agree, so a pin caught mid-edge cannot show a one-cycle glitch
	function automatic tgp_byte_type tgp_filter(input tgp_byte_type held,
		input tgp_byte_type older, input tgp_byte_type newer);
		tgp_byte_type same;
		same = ~(older ^ newer);
		return (held & ~same) | (newer & same);
	endfunction

	// apb phases; registers answer in the first access cycle, no wait states
	assign setup_phase = i_psel && !i_penable;
	assign access_phase = i_psel && i_penable;
	assign wr_en = access_phase && i_pwrite;
	// read data is taken in setup so it stands while pready does
	assign rd_en = setup_phase && !i_pwrite;

	// register selects; only the exact word address hits
	assign sel_pin = tgp_addr_is(i_paddr, `TGP_OFF_PIN_DATA);
	assign sel_latch = tgp_addr_is(i_paddr, `TGP_OFF_LATCH);
	assign sel_dir = tgp_addr_is(i_paddr, `TGP_OFF_DIR);
	assign sel_ctl = tgp_addr_is(i_paddr, `TGP_OFF_PERIPH);
	assign hit = sel_pin || sel_latch || sel_dir || sel_ctl;

	// both data addresses write the latch; pins are never written directly
	assign wr_latch = wr_en && (sel_pin || sel_latch);
	assign wr_dir = wr_en && sel_dir;
	assign wr_ctl = wr_en && sel_ctl;

	// read selection; an unmapped address reads zero
	assign rdsel = sel_pin ? pin_q :
		sel_latch ? latch_q :
		sel_dir ? dir_q :
		sel_ctl ? {3'h0, ctl_q} : 8'h00;
	assign prdata_d = {24'h00_0000, rdsel};
	assign pready_d = setup_phase;
	assign pslverr_d = setup_phase && !hit;

	// control bits by name
	assign osc_en = ctl_q[`TGP_CTL_OSC];
	assign cmp2_en = ctl_q[`TGP_CTL_CMP2];
	assign ecmp_en = ctl_q[`TGP_CTL_ECMP];
	assign pwma_en = ctl_q[`TGP_CTL_PWMA];
	assign shdn_float = ctl_q[`TGP_CTL_SHDN_Z];

	// unit two sits here only while the pin select is high
	assign unit2_here = cmp2_en && i_capture_two_pin_select;

	// drivers need direction 0; the oscillator beats them on pins 0 and 1
	assign cmp2_drives = unit2_here && !dir_q[1] && !osc_en;
	assign pwma_drives = pwma_en && !dir_q[2];
	// pwm channel a beats the plain compare output on the shared pin
	assign ecmp_drives = ecmp_en && !dir_q[2] && !pwma_en;
	assign pwma_floats = pwma_drives && shdn_float && i_pwm_shutdown;

	// capture and counter inputs need direction 1
	assign cmp2_listens = unit2_here && dir_q[1] && !osc_en;
	assign ecmp_listens = ecmp_en && dir_q[2];
	assign tcki_listens = dir_q[0] && !osc_en;

	// peripheral-side next values; the counter input holds while masked
	assign cmp2_cap_d = cmp2_listens && pin_q[1];
	assign alt_route_d = cmp2_en && !i_capture_two_pin_select;
	assign ecmp_cap_d = ecmp_listens && pin_q[2];
	assign tcki_d = tcki_listens ? pin_q[0] : o_timer_counter_clock_in;
	assign osc_active_d = osc_en;
	assign pin_d = tgp_filter(pin_q, s2_q, s3_q);

	// per-pin output value and enable; peripherals beat the latch
	always_comb begin
		out_d = latch_q;
		oe_d = ~dir_q;
		if (cmp2_drives) begin
			out_d[1] = i_cmp2_out;
		end
		if (pwma_drives) begin
			out_d[2] = i_pwma_out;
			oe_d[2] = !pwma_floats;
		end else if (ecmp_drives) begin
			out_d[2] = i_ecmp_out;
		end
		if (osc_en) begin
			// oscillator owns both pins whatever direction says
			out_d[1:0] = 2'h0;
			oe_d[1:0] = 2'h0;
		end
	end

	// three sampler stages; the pins are not on this clock
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= 8'h00;
			s2_q <= 8'h00;
			s3_q <= 8'h00;
		end else begin
			s1_q <= i_pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// filtered pin levels, costs one more cycle of input latency
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_q <= 8'h00;
		end else begin
			pin_q <= pin_d;
		end
	end

	// output latch, written through either data address
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			latch_q <= `TGP_RST_LATCH;
		end else if (wr_latch) begin
			latch_q <= i_pwdata[7:0];
		end
	end

	// direction bits; power-on leaves every pin an input
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			dir_q <= `TGP_RST_DIR;
		end else if (wr_dir) begin
			dir_q <= i_pwdata[7:0];
		end
	end

	// peripheral control; upper data bits are dropped on purpose
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ctl_q <= `TGP_RST_PERIPH;
		end else if (wr_ctl) begin
			ctl_q <= i_pwdata[`TGP_CTL_WIDTH-1:0];
		end
	end

	// read data holds until the next read setup
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			o_prdata <= prdata_d;
		end
	end

	// ready stands for exactly the first access cycle
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pready <= 1'b0;
		end else begin
			o_pready <= pready_d;
		end
	end

	// error flag rides with ready on an unmapped address
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pslverr <= 1'b0;
		end else begin
			o_pslverr <= pslverr_d;
		end
	end

	// pin levels leave from a flop so the pads see no decode glitches
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pin_out <= 8'h00;
		end else begin
			o_pin_out <= out_d;
		end
	end

	// drive enables; all low in reset so every pin starts as an input
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pin_oe <= 8'h00;
		end else begin
			o_pin_oe <= oe_d;
		end
	end

	// peripheral-side outputs
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cmp2_capture_in <= 1'b0;
			o_cmp2_alt_route <= 1'b0;
			o_ecmp_capture_in <= 1'b0;
			o_timer_counter_clock_in <= 1'b0;
			o_timer_osc_active <= 1'b0;
		end else begin
			o_cmp2_capture_in <= cmp2_cap_d;
			o_cmp2_alt_route <= alt_route_d;
			o_ecmp_capture_in <= ecmp_cap_d;
			o_timer_counter_clock_in <= tcki_d;
			o_timer_osc_active <= osc_active_d;
		end
	end

	// the pin select is a configuration level, so no sampler is placed on it;
	// a user changing it at run time may see one cycle of mixed routing

	// the capture inputs follow the filtered pin, so a capture edge reaches
	// the unit about five cycles after the pad moves

	// pins 3 to 7 have no override here; the serial units hook in elsewhere
endmodule

// [include/tgp_params.svh]
// register offsets, reset values and control bit positions for the third gpio port
// What this block does
// - eight pins, each with one direction bit and one output latch bit
// - direction bit 1 turns the pin driver off so the pin is input
// - direction 0 and no peripheral owner drives the latch value out
// - latch register reads back latched values, not pin levels
// - pin select 1, the default, routes compare unit two to pin 1
// - pin select 0 routes compare unit two to the other port's pin
// - an active peripheral may force a pin to input, never to output
// - direction register reads stored bits despite peripheral overrides
// - after power-on reset all pins are digital inputs
// - timer oscillator enabled takes pins 0 and 1, digital io off
// - unit two on pin 1: direction 0 drives compare output, 1 captures
// - pin 2 direction 0: enhanced unit output beats latch; 1 captures
// - pwm channel a beats latch, may float during pwm shutdown
// - don't-care direction functions ignore the direction bit
`ifndef TGP_PARAMS_SVH
`define TGP_PARAMS_SVH
`define TGP_OFF_PIN_DATA 12'h000
`define TGP_OFF_LATCH 12'h004
`define TGP_OFF_DIR 12'h008
`define TGP_OFF_PERIPH 12'h00c
`define TGP_RST_LATCH 8'h00
`define TGP_RST_DIR 8'hff
`define TGP_RST_PERIPH 5'h00
`define TGP_CTL_OSC 0
`define TGP_CTL_CMP2 1
`define TGP_CTL_ECMP 2
`define TGP_CTL_PWMA 3
`define TGP_CTL_SHDN_Z 4
`define TGP_CTL_WIDTH 5
`endif

// [include/tgp_pkg.sv]
// types shared by the third gpio port
package tgp_pkg;
	typedef logic [7:0] tgp_byte_type;
	typedef logic [31:0] tgp_word_type;
endpackage

// [dv/tgp_port_props.sv]
// port checker for the third gpio port
`timescale 1ns/1ns
module tgp_port_props(
	input wire logic i_core_clk,i_rst,i_psel,i_penable,o_pready,
	input wire logic o_pslverr,o_timer_osc_active,o_cmp2_alt_route,
	input wire logic i_capture_two_pin_select,
	input wire tgp_pkg::tgp_byte_type o_pin_oe
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	property p_rst; $fell(i_rst) |-> o_pin_oe == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("pin driven");
	property p_osc; o_timer_osc_active && $past(o_timer_osc_active) |->
		o_pin_oe[1:0] == 2'b00; endproperty
	a_osc: assert property (p_osc) else $error("osc pin driven");
	property p_def; i_capture_two_pin_select && $past(
		i_capture_two_pin_select) |-> !o_cmp2_alt_route; endproperty
	a_def: assert property (p_def) else $error("bad route");
	property p_alt; o_cmp2_alt_route |-> !$past(i_capture_two_pin_select);
	endproperty
	a_alt: assert property (p_alt) else $error("bad alt");
	property p_ans; i_psel && !i_penable |=> o_pready; endproperty
	a_ans: assert property (p_ans) else $error("no ready");
	property p_acc; o_pready |-> i_psel && i_penable; endproperty
	a_acc: assert property (p_acc) else $error("stray ready");
	property p_one; o_pready |=> !o_pready; endproperty
	a_one: assert property (p_one) else $error("long ready");
	property p_err; o_pslverr |-> o_pready; endproperty
	a_err: assert property (p_err) else $error("lone error");
	c_err: cover property (o_pslverr);
	c_osc: cover property (o_timer_osc_active);
	c_alt: cover property (o_cmp2_alt_route);
endmodule
bind tgp_port tgp_port_props u_props(.*);

// [dv/tgp_pins_model.sv]
// board pins: device level where it drives, outside source elsewhere
`timescale 1ns/1ns
module tgp_pins_model(
	input wire tgp_pkg::tgp_byte_type i_out,i_oe,i_ext,
	output tgp_pkg::tgp_byte_type o_pin
);
	assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// [dv/tb_tgp_port.sv]
// testbench for the third gpio port
`timescale 1ns/1ns
`include "tgp_params.svh"
module tb_tgp_port;
	import tgp_pkg::*;
	logic i_core_clk=0,i_rst=1,i_psel=0,i_penable=0,i_pwrite=0,err;
	logic i_capture_two_pin_select=1,i_cmp2_out=0,i_ecmp_out=0;
	logic i_pwma_out=1,i_pwm_shutdown=0,o_pready,o_pslverr,o_cmp2_capture_in;
	logic o_cmp2_alt_route,o_ecmp_capture_in,o_timer_counter_clock_in;
	logic o_timer_osc_active;
	logic [11:0] i_paddr=12'h000;
	tgp_word_type i_pwdata=32'h0,o_prdata,rd;
	tgp_byte_type i_pin_in,o_pin_out,o_pin_oe,ext=8'h3d;
	int errors=0,compares=0;
	tgp_port u_dut(.*);
	tgp_pins_model u_pins(.i_out(o_pin_out),.i_oe(o_pin_oe),.i_ext(ext),
		.o_pin(i_pin_in));
	always #20 i_core_clk = ~i_core_clk;
	task automatic chk(input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// request held until ready is seen high at an edge
	task automatic xfer(input logic w, input logic [11:0] a, tgp_word_type d);
		@(posedge i_core_clk);
		{i_psel,i_pwrite,i_paddr,i_pwdata} <= {1'b1,w,a,d};
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		do @(posedge i_core_clk); while (o_pready !== 1'b1);
		{rd,err} = {o_prdata,o_pslverr};
		{i_psel,i_penable} <= 2'b00;
	endtask
	// pins follow one cycle after the write edge
	task automatic wr(input logic [11:0] a, tgp_word_type d);
		xfer(1'b1, a, d);
		repeat (2) @(posedge i_core_clk);
	endtask
	task automatic rdc(input logic [11:0] a, tgp_word_type e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task print_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(posedge i_core_clk);
		chk(o_pin_oe, 8'h00);
		rdc(`TGP_OFF_DIR, `TGP_RST_DIR);
		wr(`TGP_OFF_DIR, 32'h0f);
		wr(`TGP_OFF_LATCH, 32'ha5);
		repeat (4) @(posedge i_core_clk);
		chk(o_pin_oe, 8'hf0);
		chk(o_pin_out & 8'hf0, 8'ha0);
		chk(o_timer_counter_clock_in, 1'b1);
		rdc(`TGP_OFF_PIN_DATA, 32'had);
		wr(`TGP_OFF_PIN_DATA, 32'h5a);
		rdc(`TGP_OFF_LATCH, 32'h5a);
		wr(`TGP_OFF_DIR, 32'h00);
		wr(`TGP_OFF_PERIPH, 32'h0f);
		chk(o_pin_oe[1:0], 2'b00);
		chk(o_pin_out[2], 1'b1);
		chk(o_timer_osc_active, 1'b1);
		rdc(`TGP_OFF_DIR, 32'h00);
		i_ecmp_out <= 1'b1;
		wr(`TGP_OFF_PERIPH, 32'h16);
		chk(o_pin_out[2:1], 2'b10);
		i_pwma_out <= 1'b0;
		wr(`TGP_OFF_PERIPH, 32'h1e);
		chk(o_pin_out[2], 1'b0);
		{i_pwm_shutdown,i_capture_two_pin_select} <= 2'b10;
		repeat (3) @(posedge i_core_clk);
		chk({o_pin_oe[2],o_pin_out[1],o_cmp2_alt_route}, 3'b011);
		ext <= 8'h3f;
		i_capture_two_pin_select <= 1'b1;
		wr(`TGP_OFF_DIR, 32'h06);
		wr(`TGP_OFF_PERIPH, 32'h06);
		repeat (6) @(posedge i_core_clk);
		chk({o_cmp2_capture_in,o_ecmp_capture_in}, 2'b11);
		chk(o_pin_oe, 8'hf9);
		chk(o_timer_osc_active, 1'b0);
		rdc(12'h010, 32'h0);
		chk(err, 1'b1);
		print_verdict;
	end
	// a hung handshake must still end the run with a verdict
	initial begin
		repeat (3000) @(posedge i_core_clk);
		errors++;
		print_verdict;
	end
endmodule
